/* File: hdl/ccr_core_config_readback.sv */
/*
 * ccr_core_config_readback: coprocessor register 16, selects 0 and 1.
 * reads return data one cycle after the strobe; writes to select 0 load
 * only the policy field.
 * assumes: strobes come from core logic on mclk; no synchroniser needed.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - capability 0 bit 31 always reads one.
// - instruction scratch-pad presence bit 24 reads zero.
// - data scratch-pad presence bit 23 reads zero.
// - user instruction extension bit 22 reads zero.
// - simple byte-enable bit 21 reads one.
// - multiply-divide kind bit 20 reads zero, fast unit.
// - merge policy bits 18:17 read binary 10.
// - burst order bit 16 reads zero, sequential.
// - endian select bit 15 reads zero, little-endian.
// - family type bits 14:13 read 00.
// - release level bits 12:10 read 001.
// - bits 30:25, 19 and 9:3 of capability 0 read zero.
// - policy bits 2:0 writable, 010 default, 011 recommended, others reserved.
// - capability 1 bit 31 always reads one.
// - translation size bits 30:25 read zero.
// - capability 1 bits 24:5 read zero.
// - performance counter bit 4 reads one.
// - watch register bit 3 reads one.
// - code compression bit 2 reads zero.
// - debug port bit 1 reads one.
// - floating-point bit 0 reads one.
module ccr_core_config_readback
    import ccr_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic cop_rd,
    input wire logic cop_wr,
    input wire logic [4:0] cop_regnum,
    input wire logic [2:0] cop_sel,
    input wire logic [31:0] cop_wdata,
    output logic [31:0] cop_rdata,
    output logic cop_rvalid,
    output logic cop_hit
);
    typedef struct packed {
        logic [2:0] policy;
        logic [31:0] rdata;
        logic rvalid;
    } ccr_state_t;

    ccr_state_t st_q;
    ccr_state_t st_d;
    logic [31:0] cap0_word;
    logic [31:0] cap1_word;
    logic rd_cap0;
    logic rd_cap1;

    function automatic logic sel_match(
        input logic [4:0] regnum,
        input logic [2:0] sel,
        input logic [2:0] want
    );
        sel_match = (regnum == CCR_REGNUM) && (sel == want);
    endfunction : sel_match

    ccr_field_pack i_ccr_field_pack (
        .cached_segment_policy(st_q.policy),
        .cap0_word(cap0_word),
        .cap1_word(cap1_word)
    );

    assign cop_hit = sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0)
        || sel_match(cop_regnum, cop_sel, CCR_SEL_CAP1);
    assign cop_rdata = st_q.rdata;
    assign cop_rvalid = st_q.rvalid;
    // read strobes per capability word, shared by the checks below
    assign rd_cap0 = cop_rd && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0);
    assign rd_cap1 = cop_rd && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP1);

    always_comb
    begin
        st_d = st_q;
        st_d.rvalid = cop_rd;
        if (cop_rd)
        begin
            // unmapped selects read zero
            if (sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0))
                st_d.rdata = cap0_word;
            else if (sel_match(cop_regnum, cop_sel, CCR_SEL_CAP1))
                st_d.rdata = cap1_word;
            else
                st_d.rdata = 32'h0000_0000;
        end
        // reserved codes are software's to avoid; stored as written
        if (cop_wr && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0))
            st_d.policy = cop_wdata[CCR0_POL_LSB +: 3];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_q.policy <= CCR_POL_RESET;
            st_q.rdata <= 32'h0000_0000;
            st_q.rvalid <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    property p_cap0_fixed;
        @(posedge mclk) disable iff (reset)
        cop_rd && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0) |=>
            cop_rvalid && (cop_rdata[31:3] == 29'h1004_8080);
    endproperty
    a_cap0_fixed: assert property (p_cap0_fixed)
        else $error("capability 0 fixed bits wrong");

    property p_cap1_fixed;
        @(posedge mclk) disable iff (reset)
        cop_rd && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP1) |=>
            cop_rvalid && (cop_rdata == 32'h8000_001B);
    endproperty
    a_cap1_fixed: assert property (p_cap1_fixed)
        else $error("capability 1 value wrong");

    property p_policy_write;
        @(posedge mclk) disable iff (reset)
        cop_wr && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0) && !cop_rd ##1 cop_rd
            && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0) |=>
            cop_rdata[2:0] == $past(cop_wdata[2:0], 2);
    endproperty
    a_policy_write: assert property (p_policy_write)
        else $error("policy write not read back");

    property p_policy_hold;
        @(posedge mclk) disable iff (reset)
        !(cop_wr && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0)) |=> $stable(st_q.policy);
    endproperty
    a_policy_hold: assert property (p_policy_hold)
        else $error("policy changed without write");

    property p_rvalid;
        @(posedge mclk) disable iff (reset)
        cop_rd |=> cop_rvalid ##1 (cop_rvalid == $past(cop_rd));
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read answer timing wrong");

    property p_cap0_next;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> cop_rdata[CCR0_NEXT_BIT];
    endproperty
    a_cap0_next: assert property (p_cap0_next)
        else $error("capability 0 next bit clear");

    property p_ipad_absent;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> !cop_rdata[CCR0_IPAD_BIT];
    endproperty
    a_ipad_absent: assert property (p_ipad_absent)
        else $error("instruction scratch-pad bit set");

    property p_dpad_absent;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> !cop_rdata[CCR0_DSP_BIT];
    endproperty
    a_dpad_absent: assert property (p_dpad_absent)
        else $error("data scratch-pad bit set");

    property p_uext_absent;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> !cop_rdata[CCR0_UEXT_BIT];
    endproperty
    a_uext_absent: assert property (p_uext_absent)
        else $error("user instruction extension bit set");

    property p_sbe_only;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> cop_rdata[CCR0_SBE_BIT];
    endproperty
    a_sbe_only: assert property (p_sbe_only)
        else $error("simple byte-enable bit clear");

    property p_mdiv_fast;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> !cop_rdata[CCR0_MDK_BIT];
    endproperty
    a_mdiv_fast: assert property (p_mdiv_fast)
        else $error("multiply-divide kind bit set");

    property p_merge;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> cop_rdata[CCR0_MRG_LSB +: 2] == CCR_MERGE_ALLOWED;
    endproperty
    a_merge: assert property (p_merge)
        else $error("merge policy field wrong");

    property p_burst_seq;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> !cop_rdata[CCR0_BURST_BIT];
    endproperty
    a_burst_seq: assert property (p_burst_seq)
        else $error("burst order bit set");

    property p_little_endian;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> !cop_rdata[CCR0_END_BIT];
    endproperty
    a_little_endian: assert property (p_little_endian)
        else $error("endian select bit set");

    property p_isa_type;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> cop_rdata[CCR0_ISA_LSB +: 2] == CCR_ISA_BASE32;
    endproperty
    a_isa_type: assert property (p_isa_type)
        else $error("family type field wrong");

    property p_isa_rel;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> cop_rdata[CCR0_REL_LSB +: 3] == CCR_ISA_REL2;
    endproperty
    a_isa_rel: assert property (p_isa_rel)
        else $error("release level field wrong");

    property p_cap0_unused;
        @(posedge mclk) disable iff (reset)
        rd_cap0 |=> cop_rdata[CCR0_NEXT_BIT-1:CCR0_IPAD_BIT+1] == '0
            && !cop_rdata[CCR0_MDK_BIT-1]
            && cop_rdata[CCR0_REL_LSB-1:CCR0_POL_LSB+3] == '0;
    endproperty
    a_cap0_unused: assert property (p_cap0_unused)
        else $error("capability 0 unused bits not zero");

    // reset must leave the prefetch-uncached default behind
    property p_policy_reset;
        @(posedge mclk) disable iff (reset)
        $fell(reset) |-> st_q.policy == CCR_POL_RESET;
    endproperty
    a_policy_reset: assert property (p_policy_reset)
        else $error("policy not default after reset");

    property p_cap1_next;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_NEXT_BIT];
    endproperty
    a_cap1_next: assert property (p_cap1_next)
        else $error("capability 1 next bit clear");

    property p_tsize_none;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_TSIZE_LSB +: 6] == CCR_TSIZE_NONE;
    endproperty
    a_tsize_none: assert property (p_tsize_none)
        else $error("translation size not zero");

    property p_cap1_unused;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_TSIZE_LSB-1:CCR1_PERF_BIT+1] == '0;
    endproperty
    a_cap1_unused: assert property (p_cap1_unused)
        else $error("capability 1 unused bits not zero");

    property p_perf;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_PERF_BIT];
    endproperty
    a_perf: assert property (p_perf)
        else $error("performance counter bit clear");

    property p_watch;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_WR_BIT];
    endproperty
    a_watch: assert property (p_watch)
        else $error("watch register bit clear");

    property p_comp_absent;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> !cop_rdata[CCR1_COMP_BIT];
    endproperty
    a_comp_absent: assert property (p_comp_absent)
        else $error("code compression bit set");

    property p_dbg;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_DBG_BIT];
    endproperty
    a_dbg: assert property (p_dbg)
        else $error("debug port bit clear");

    property p_fpu;
        @(posedge mclk) disable iff (reset)
        rd_cap1 |=> cop_rdata[CCR1_FPU_BIT];
    endproperty
    a_fpu: assert property (p_fpu)
        else $error("floating-point bit clear");

    property p_cap1_readonly;
        @(posedge mclk) disable iff (reset)
        cop_wr && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP1) |=> $stable(st_q.policy);
    endproperty
    a_cap1_readonly: assert property (p_cap1_readonly)
        else $error("capability 1 write changed policy");

    c_rd0: cover property (@(posedge mclk) disable iff (reset)
        cop_rd && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP0));
    c_rd1: cover property (@(posedge mclk) disable iff (reset)
        cop_rd && sel_match(cop_regnum, cop_sel, CCR_SEL_CAP1));
    c_wr_cached: cover property (@(posedge mclk) disable iff (reset)
        cop_wr && cop_hit && cop_wdata[2:0] == 3'h3);
    c_rd_unmapped: cover property (@(posedge mclk) disable iff (reset)
        cop_rd && !cop_hit);
    c_wr_then_rd: cover property (@(posedge mclk) disable iff (reset)
        cop_wr && cop_hit ##1 cop_rd && cop_hit);
endmodule : ccr_core_config_readback
`default_nettype wire

/* File: hdl/ccr_field_pack.sv */
/*
 * ccr_field_pack: assembles both capability words from fixed values and
 * the live cached-segment policy field.
 * assumes: policy comes from a register in the caller.
 */
`timescale 1ns/100ps
`default_nettype none
module ccr_field_pack
    import ccr_pkg::*;
(
    input wire logic [2:0] cached_segment_policy,
    output logic [31:0] cap0_word,
    output logic [31:0] cap1_word
);
    always_comb
    begin
        cap0_word = 32'h0000_0000;
        cap0_word[CCR0_NEXT_BIT] = 1'b1;
        cap0_word[CCR0_IPAD_BIT] = 1'b0;
        cap0_word[CCR0_DSP_BIT] = 1'b0;
        cap0_word[CCR0_UEXT_BIT] = 1'b0;
        cap0_word[CCR0_SBE_BIT] = 1'b1;
        cap0_word[CCR0_MDK_BIT] = 1'b0;
        cap0_word[CCR0_MRG_LSB +: 2] = CCR_MERGE_ALLOWED;
        cap0_word[CCR0_BURST_BIT] = 1'b0;
        cap0_word[CCR0_END_BIT] = 1'b0;
        cap0_word[CCR0_ISA_LSB +: 2] = CCR_ISA_BASE32;
        cap0_word[CCR0_REL_LSB +: 3] = CCR_ISA_REL2;
        cap0_word[CCR0_POL_LSB +: 3] = cached_segment_policy;
        cap1_word = 32'h0000_0000;
        cap1_word[CCR1_NEXT_BIT] = 1'b1;
        cap1_word[CCR1_TSIZE_LSB +: 6] = CCR_TSIZE_NONE;
        cap1_word[CCR1_PERF_BIT] = 1'b1;
        cap1_word[CCR1_WR_BIT] = 1'b1;
        cap1_word[CCR1_COMP_BIT] = 1'b0;
        cap1_word[CCR1_DBG_BIT] = 1'b1;
        cap1_word[CCR1_FPU_BIT] = 1'b1;
    end
endmodule : ccr_field_pack
`default_nettype wire

/* File: hdl/ccr_pkg.sv */
/*
 * ccr_pkg: register numbers, field positions and fixed field values of
 * the two core capability registers.
 * assumes: read by ccr_field_pack, ccr_core_config_readback and tb_core_config_readback.
 */
package ccr_pkg;
    localparam int CCR_REGNUM_W = 5;
    localparam int CCR_SEL_W = 3;
    localparam logic [4:0] CCR_REGNUM = 5'h10;
    localparam logic [2:0] CCR_SEL_CAP0 = 3'h0;
    localparam logic [2:0] CCR_SEL_CAP1 = 3'h1;

    // capability 0 layout
    localparam int CCR0_NEXT_BIT = 31;
    localparam int CCR0_IPAD_BIT = 24;
    localparam int CCR0_DSP_BIT = 23;
    localparam int CCR0_UEXT_BIT = 22;
    localparam int CCR0_SBE_BIT = 21;
    localparam int CCR0_MDK_BIT = 20;
    localparam int CCR0_MRG_LSB = 17;
    localparam int CCR0_BURST_BIT = 16;
    localparam int CCR0_END_BIT = 15;
    localparam int CCR0_ISA_LSB = 13;
    localparam int CCR0_REL_LSB = 10;
    localparam int CCR0_POL_LSB = 0;

    localparam logic [1:0] CCR_MERGE_ALLOWED = 2'h2;
    localparam logic [1:0] CCR_ISA_BASE32 = 2'h0;
    localparam logic [2:0] CCR_ISA_REL2 = 3'h1;

    typedef enum logic [2:0] {
        CCR_POL_PREF_UNCACHED = 3'h2,
        CCR_POL_PREF_CACHED = 3'h3
    } ccr_policy_t;
    localparam logic [2:0] CCR_POL_RESET = 3'h2;

    // capability 1 layout
    localparam int CCR1_NEXT_BIT = 31;
    localparam int CCR1_TSIZE_LSB = 25;
    localparam logic [5:0] CCR_TSIZE_NONE = 6'h00;
    localparam int CCR1_PERF_BIT = 4;
    localparam int CCR1_WR_BIT = 3;
    localparam int CCR1_COMP_BIT = 2;
    localparam int CCR1_DBG_BIT = 1;
    localparam int CCR1_FPU_BIT = 0;
endpackage : ccr_pkg

/* File: test/tb_core_config_readback.sv */
/*
 * tb_core_config_readback: self-checking bench for the capability
 * register pair, driving the coprocessor strobes directly.
 * assumes: hdl/ccr_pkg.sv and the design modules are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("BAD %s exp %h got %h", what, exp, got); \
        end \
    end
module tb_core_config_readback;
    import ccr_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cop_rd = 1'b0;
    logic cop_wr = 1'b0;
    logic [4:0] cop_regnum = 5'h00;
    logic [2:0] cop_sel = 3'h0;
    logic [31:0] cop_wdata = 32'h0000_0000;
    logic [31:0] cop_rdata;
    logic cop_rvalid;
    logic cop_hit;
    int error_cnt = 0;
    int samples_checked = 0;
    // next, simple byte-enable, merge 10, release 001; policy added per test
    localparam logic [31:0] CAP0 = 32'h8024_0400;
    localparam logic [31:0] CAP1 = 32'h8000_001B;

    ccr_core_config_readback i_ccr_core_config_readback (.mclk(mclk), .reset(reset),
        .cop_rd(cop_rd), .cop_wr(cop_wr), .cop_regnum(cop_regnum), .cop_sel(cop_sel),
        .cop_wdata(cop_wdata), .cop_rdata(cop_rdata), .cop_rvalid(cop_rvalid),
        .cop_hit(cop_hit));

    always #20 mclk = ~mclk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic rd(input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] exp);
        @(posedge mclk);
        cop_rd <= 1'b1;
        cop_regnum <= rn;
        cop_sel <= sl;
        #1;
        `CHK("hit", (rn == CCR_REGNUM && sl < 3'h2), cop_hit)
        @(posedge mclk);
        cop_rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, cop_rvalid)
        `CHK("rdata", exp, cop_rdata)
        @(posedge mclk);
        #1;
        // valid must not stretch past one cycle
        `CHK("rvalid low", 1'b0, cop_rvalid)
    endtask : rd

    task automatic wr(input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] d);
        @(posedge mclk);
        cop_wr <= 1'b1;
        cop_regnum <= rn;
        cop_sel <= sl;
        cop_wdata <= d;
        @(posedge mclk);
        cop_wr <= 1'b0;
    endtask : wr

    initial
    begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        rd(CCR_REGNUM, CCR_SEL_CAP0, CAP0 | 32'h2);
        rd(CCR_REGNUM, CCR_SEL_CAP0, CAP0 | 32'h2);
        rd(CCR_REGNUM, CCR_SEL_CAP1, CAP1);
        $display("test reset values done");
        // all ones except low bits 011: only the policy may follow
        wr(CCR_REGNUM, CCR_SEL_CAP0, 32'hFFFF_FFFB);
        rd(CCR_REGNUM, CCR_SEL_CAP0, CAP0 | 32'h3);
        wr(CCR_REGNUM, CCR_SEL_CAP1, 32'hFFFF_FFFF);
        rd(CCR_REGNUM, CCR_SEL_CAP1, CAP1);
        wr(5'h11, 3'h0, 32'h0000_0002);
        rd(5'h11, 3'h0, 32'h0000_0000);
        rd(CCR_REGNUM, 3'h2, 32'h0000_0000);
        rd(CCR_REGNUM, CCR_SEL_CAP0, CAP0 | 32'h3);
        $display("test writes done");
        // read and write in one cycle: read returns the old policy
        @(posedge mclk);
        cop_rd <= 1'b1;
        cop_wr <= 1'b1;
        cop_regnum <= CCR_REGNUM;
        cop_sel <= CCR_SEL_CAP0;
        cop_wdata <= 32'h0000_0002;
        @(posedge mclk);
        cop_rd <= 1'b0;
        cop_wr <= 1'b0;
        #1;
        `CHK("rdata same cycle", CAP0 | 32'h3, cop_rdata)
        rd(CCR_REGNUM, CCR_SEL_CAP0, CAP0 | 32'h2);
        // write then read on the very next edge: read sees the new policy
        @(posedge mclk);
        cop_wr <= 1'b1;
        cop_regnum <= CCR_REGNUM;
        cop_sel <= CCR_SEL_CAP0;
        cop_wdata <= 32'h0000_0003;
        @(posedge mclk);
        cop_wr <= 1'b0;
        cop_rd <= 1'b1;
        @(posedge mclk);
        cop_rd <= 1'b0;
        #1;
        `CHK("rdata back to back", CAP0 | 32'h3, cop_rdata)
        wr(CCR_REGNUM, CCR_SEL_CAP0, 32'h0000_0003);
        $display("test same cycle done");
        // second reset in mid-run must restore the default policy
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("rdata in reset", 32'h0000_0000, cop_rdata)
        `CHK("rvalid in reset", 1'b0, cop_rvalid)
        @(posedge mclk);
        reset <= 1'b0;
        rd(CCR_REGNUM, CCR_SEL_CAP0, CAP0 | 32'h2);
        $display("test second reset done");
        summarize();
    end

    initial
    begin
        // tests take under 100 cycles; generous margin
        #(40 * 3000);
        error_cnt++;
        $display("watchdog expired");
        summarize();
    end
endmodule : tb_core_config_readback
`default_nettype wire
